// ### periodic_timer_modes.sv
/*
 * Ten-bit periodic timer with comparators A and P, an APB register file and
 * five modes: compare match, timer/counter, PWM, single pulse and capture.
 * Assumes one 50 MHz clock pclk; pins arrive asynchronously.
 */
module periodic_timer_modes
   import timer_pkg::*;
   #(
   parameter int ADDR_W = 8
   )
   (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              timer_pin_0,
   input  wire logic              timer_pin_1,
   input  wire logic              external_clock_pin,
   output logic      [1:0]        timer_pin_out,
   output logic      [1:0]        timer_pin_oe
   );

   // =======================================================================
   // State
   logic [7:0]       ctrl1_ff;
   logic             pause_ff;
   logic [2:0]       clk_sel_ff;
   logic             counter_on_ff;
   logic             on_last_ff;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] compare_a_value_ff;
   logic [CNT_W-1:0] period_value_ff;
   logic             match_a_flag_ff;
   logic             match_p_flag_ff;
   logic             out_level_ff;
   logic [7:0]       presc_ff;
   logic             pready_ff;
   logic [31:0]      prdata_ff;
   logic             pslverr_ff;
   logic [1:0]       timer_pin_out_ff;
   logic [1:0]       timer_pin_oe_ff;
   logic [31:0]      rd_word;
   logic             addr_hit;

   pin_events_if ev ();

   pin_sync u_pin_sync
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .pins_async ({external_clock_pin, timer_pin_1, timer_pin_0}),
      .ev         (ev.producer)
   );

   // =======================================================================
   // Control fields
   wire [1:0] mode_sel   = ctrl1_ff[7:6];
   wire       mode_sel_hi = mode_sel[1];
   wire       mode_sel_lo = mode_sel[0];
   wire [1:0] pin_function = ctrl1_ff[5:4];
   wire       output_initial_level  = ctrl1_ff[3];
   wire       output_invert         = ctrl1_ff[2];
   wire       capture_source_select = ctrl1_ff[1];
   wire       clear_source_select   = ctrl1_ff[0];

   // Mode decode.
   // mode field decode
   wire is_compare = ~mode_sel_hi & ~mode_sel_lo;
   wire is_capture = ~mode_sel_hi & mode_sel_lo;
   wire is_timer   = mode_sel_hi & mode_sel_lo;
   wire is_cmp     = is_compare | is_timer;
   wire is_pwm     = mode_sel_hi & ~mode_sel_lo & (pin_function != PF_TOGGLE);
   wire is_single  = mode_sel_hi & ~mode_sel_lo & (pin_function == PF_TOGGLE);

   // =======================================================================
   // APB slave: one wait state, pready pulses in the second access cycle.
   wire acc     = psel & penable;
   wire rd_take = acc & ~pready_ff;
   wire wr_en   = acc & pready_ff & pwrite & pstrb[0] & addr_hit;
   wire [7:0] wb = pwdata[7:0];
   wire [ADDR_W-1:0] a = paddr;

   wire we_ctrl0  = wr_en & (a == ADDR_W'(OFF_CTRL0));
   wire we_ctrl1  = wr_en & (a == ADDR_W'(OFF_CTRL1));
   wire we_a_low  = wr_en & (a == ADDR_W'(OFF_COMPARE_A_LOW));
   wire we_a_high = wr_en & (a == ADDR_W'(OFF_COMPARE_A_HIGH));
   wire we_p_low  = wr_en & (a == ADDR_W'(OFF_PERIOD_LOW));
   wire we_p_high = wr_en & (a == ADDR_W'(OFF_PERIOD_HIGH));
   wire we_flags  = wr_en & (a == ADDR_W'(OFF_FLAGS));

   // Read decode; unmapped addresses read zero and raise pslverr.
   always_comb
   begin
      rd_word  = 32'h0000_0000;
      addr_hit = 1'b1;
      if (a == ADDR_W'(OFF_CTRL0))
         rd_word[7:0] = {pause_ff, clk_sel_ff, counter_on_ff, 3'h0};
      else if (a == ADDR_W'(OFF_CTRL1))
         rd_word[7:0] = ctrl1_ff;
      else if (a == ADDR_W'(OFF_COUNT_LOW))
         rd_word[7:0] = count_ff[7:0];
      else if (a == ADDR_W'(OFF_COUNT_HIGH))
         rd_word[1:0] = count_ff[9:8];
      else if (a == ADDR_W'(OFF_COMPARE_A_LOW))
         rd_word[7:0] = compare_a_value_ff[7:0];
      else if (a == ADDR_W'(OFF_COMPARE_A_HIGH))
         rd_word[1:0] = compare_a_value_ff[9:8];
      else if (a == ADDR_W'(OFF_PERIOD_LOW))
         rd_word[7:0] = period_value_ff[7:0];
      else if (a == ADDR_W'(OFF_PERIOD_HIGH))
         rd_word[1:0] = period_value_ff[9:8];
      else if (a == ADDR_W'(OFF_FLAGS))
         rd_word[1:0] = {match_p_flag_ff, match_a_flag_ff};
      else
         addr_hit = 1'b0;
   end

   // Bus answer registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= rd_take;
         prdata_ff  <= rd_take ? rd_word : prdata_ff;
         pslverr_ff <= rd_take & ~addr_hit;
      end
   end

   // =======================================================================
   // Counter clock selection: pclk, free-running prescaler taps or an external pin edge.
   wire ext_rise = ev.rise[PIN_EXT];
   wire ext_fall = ev.fall[PIN_EXT];
   wire ext_edge = (clk_sel_ff == CKS_EXT_FALL) ? ext_fall : ext_rise;
   wire clk_tick =
      (clk_sel_ff == CKS_FH)   ? 1'b1 :
      (clk_sel_ff == CKS_SYS4) ? ((presc_ff & DIV4_MASK) == DIV4_MASK) :
      (clk_sel_ff == CKS_FH16) ? ((presc_ff & DIV16_MASK) == DIV16_MASK) :
      (clk_sel_ff == CKS_FH64) ? ((presc_ff & DIV64_MASK) == DIV64_MASK) :
      (clk_sel_ff[1])          ? ext_edge :
                                 (presc_ff == TBC_MASK);

   wire on_rise = counter_on_ff & ~on_last_ff;
   wire tick    = counter_on_ff & ~pause_ff & clk_tick & ~on_rise;
   wire [CNT_W-1:0] cnt_inc = count_ff + 10'h001;

   // Comparator P; a zero period matches on the wrap from 3FF.
   // zero period gives 1024 counts
   wire p_hit = tick & (cnt_inc == period_value_ff);
   wire a_hit = tick & (compare_a_value_ff != RST_VAL10) &
                (cnt_inc == compare_a_value_ff);

   // Clear sources per mode; single pulse uses neither.
   // clear on P or A match
   wire clr_p = (is_cmp & ~clear_source_select) | is_pwm | is_capture;
   wire clr_a = is_cmp & clear_source_select;
   // single pulse never cleared by compare
   wire cnt_clear = (clr_p & p_hit) | (clr_a & a_hit);

   // Capture edge selection.
   // source and edge choice
   wire cap_r = capture_source_select ? ext_rise :
                (ev.rise[PIN_TP0] | ev.rise[PIN_TP1]);
   wire cap_f = capture_source_select ? ext_fall :
                (ev.fall[PIN_TP0] | ev.fall[PIN_TP1]);
   wire cap_evt = is_capture &
                  (((pin_function == PF_NONE) & cap_r) |
                   ((pin_function == PF_LOW)  & cap_f) |
                   ((pin_function == PF_HIGH) & (cap_r | cap_f)));

   // Flag sources.
   // capture raises A flag
   wire set_a = (a_hit & (is_cmp | is_pwm | is_single)) | cap_evt;
   // no P flag with clear-select high in compare and timer modes
   wire set_p = p_hit & ((is_cmp & ~clear_source_select) | is_pwm | is_capture);

   // Prescaler and counter.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presc_ff   <= RST_BYTE;
         count_ff   <= RST_VAL10;
         on_last_ff <= 1'b0;
      end
      else
      begin
         presc_ff   <= presc_ff + 8'h01;
         on_last_ff <= counter_on_ff;
         // zero on rise, hold when off
         if (on_rise)
            count_ff <= RST_VAL10;
         else if (tick)
            count_ff <= cnt_clear ? RST_VAL10 : cnt_inc;
      end
   end

   // =======================================================================
   // Control registers. Hardware set of counter-on beats a software clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl1_ff      <= RST_BYTE;
         pause_ff      <= 1'b0;
         clk_sel_ff    <= 3'h0;
         counter_on_ff <= 1'b0;
      end
      else
      begin
         if (we_ctrl1)
            ctrl1_ff <= wb;
         if (we_ctrl0)
         begin
            pause_ff   <= wb[CTRL0_PAUSE_BIT];
            clk_sel_ff <= wb[CTRL0_CKS_LSB +: 3];
         end
         if (is_single & ext_edge & ~counter_on_ff)
            counter_on_ff <= 1'b1;
         else if (is_single & a_hit)
            counter_on_ff <= 1'b0;
         else if (we_ctrl0)
            counter_on_ff <= wb[CTRL0_ON_BIT];
      end
   end

   // Compare and period values; a capture overrides a software write.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compare_a_value_ff <= RST_VAL10;
         period_value_ff    <= RST_VAL10;
      end
      else
      begin
         if (cap_evt)
            compare_a_value_ff <= count_ff;
         else if (we_a_low)
            compare_a_value_ff[7:0] <= wb;
         else if (we_a_high)
            compare_a_value_ff[9:8] <= wb[1:0];
         if (we_p_low)
            period_value_ff[7:0] <= wb;
         else if (we_p_high)
            period_value_ff[9:8] <= wb[1:0];
      end
   end

   // Match flags are write-one-to-clear; a new match in the same cycle wins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         match_a_flag_ff <= 1'b0;
         match_p_flag_ff <= 1'b0;
      end
      else
      begin
         match_a_flag_ff <= set_a | (match_a_flag_ff & ~(we_flags & wb[FLAG_A_BIT]));
         match_p_flag_ff <= set_p | (match_p_flag_ff & ~(we_flags & wb[FLAG_P_BIT]));
      end
   end

   // =======================================================================
   // Output waveform
   wire [10:0] period_eff = (period_value_ff == RST_VAL10) ? FULL_PERIOD :
                            {1'b0, period_value_ff};
   // duty at or above period is full
   wire pwm_active = ({1'b0, compare_a_value_ff} >= period_eff) |
                     (count_ff < compare_a_value_ff);
   // forced levels leave the counter running
   wire pwm_level = (pin_function == PF_NONE) ? ~output_initial_level :
                    (pin_function == PF_LOW)  ? output_initial_level :
                    (pwm_active ? output_initial_level : ~output_initial_level);
   wire single_level = counter_on_ff ? output_initial_level : ~output_initial_level;

   // Compare-match pin level.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_level_ff <= 1'b0;
      else if (on_rise)
         out_level_ff <= output_initial_level;
      // only an A flag event moves the pin
      else if (is_compare & a_hit)
      begin
         case (pin_function)
            PF_LOW:    out_level_ff <= 1'b0;
            PF_HIGH:   out_level_ff <= 1'b1;
            PF_TOGGLE: out_level_ff <= ~out_level_ff;
            default:   out_level_ff <= out_level_ff;
         endcase
      end
   end

   // Polarity and drive. Timer and capture modes release the pin, so a
   // pin-shared function can use it; capture would otherwise see its own
   // transitions.
   // polarity and invert
   wire pin_level = output_invert ^
                    (is_compare ? out_level_ff : is_pwm ? pwm_level : single_level);
   wire pin_drive = is_compare | is_pwm | is_single;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_pin_out_ff <= 2'b00;
         timer_pin_oe_ff  <= 2'b00;
      end
      else
      begin
         timer_pin_out_ff <= {2{pin_level & pin_drive}};
         timer_pin_oe_ff  <= {2{pin_drive}};
      end
   end

   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign timer_pin_out = timer_pin_out_ff;
   assign timer_pin_oe  = timer_pin_oe_ff;

endmodule : periodic_timer_modes

// ### periodic_timer_modes_sva.sv
/*
 * Checker for the periodic timer: APB answer timing, read-back and pin drive.
 * Assumes it is bound to periodic_timer_modes and sees only that module's ports.
 */
module periodic_timer_modes_sva
   import timer_pkg::*;
   #(
   parameter int ADDR_W = 8
   )
   (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [1:0]        timer_pin_out,
   input wire logic [1:0]        timer_pin_oe
   );
   // ====================
   // Shadow of committed control writes
   logic [7:0] ctrl1_ff;
   logic       on_ff;
   logic       wr_ok;
   logic [1:0] mode_w;

   // A write lands only at the pready edge with byte lane 0 enabled.
   assign wr_ok  = psel && penable && pready && pwrite && pstrb[0];
   assign mode_w = ctrl1_ff[7:6];

   // The shadow lets pin checks know the mode without peeking inside.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctrl1_ff <= 8'h00;
         on_ff    <= 1'b0;
      end
      else if (wr_ok && paddr == OFF_CTRL1)
         ctrl1_ff <= pwdata[7:0];
      else if (wr_ok && paddr == OFF_CTRL0)
         on_ff <= pwdata[3];

   // ====================
   // Properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_timer3;
      (mode_w == MODE_TIMER)[*3];
   endsequence
   sequence s_drive3;
      (mode_w == MODE_COMPARE || mode_w == MODE_PWM)[*3];
   endsequence

   property p_one_wait;
      s_setup ##1 s_wait |=> pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_err_unmapped;
      pready && paddr > OFF_FLAGS |-> pslverr && prdata == 32'h0;
   endproperty
   property p_count_wr;
      pready && pwrite && paddr == OFF_COUNT_LOW |-> !pslverr;
   endproperty
   property p_high_zero;
      pready && !pwrite && (paddr == OFF_COMPARE_A_HIGH || paddr == OFF_PERIOD_HIGH)
         |-> prdata[31:2] == 30'h0;
   endproperty
   property p_timer_released;
      s_timer3 |-> timer_pin_oe == 2'b00 && timer_pin_out == 2'b00;
   endproperty
   property p_drive;
      s_drive3 |-> timer_pin_oe == 2'b11;
   endproperty
   property p_on_level;
      wr_ok && paddr == OFF_CTRL0 && pwdata[3] && !on_ff && mode_w == MODE_COMPARE
         && !ctrl1_ff[2] |-> ##3 timer_pin_out == {2{ctrl1_ff[3]}};
   endproperty

   a_one_wait: assert property (p_one_wait)
      else $error("pready missing after one wait state");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("unmapped access without error or with data");
   a_count_wr: assert property (p_count_wr)
      else $error("count write flagged as error");
   a_high_zero: assert property (p_high_zero)
      else $error("high byte upper bits not zero");
   a_timer_released: assert property (p_timer_released)
      else $error("pin driven in timer mode");
   a_drive: assert property (p_drive)
      else $error("pin not driven in output mode");
   a_on_level: assert property (p_on_level)
      else $error("pin not at initial level after start");
endmodule : periodic_timer_modes_sva

bind periodic_timer_modes periodic_timer_modes_sva #(.ADDR_W(ADDR_W)) chk_u (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe));

// ### periodic_timer_modes_test.sv
/*
 * Self-checking bench for the periodic timer, one task per scenario.
 * Assumes the pin model on the pins and the checker bound from its own file.
 */
module periodic_timer_modes_test
   import timer_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tp0;
   logic        tp1;
   logic        tck;
   logic [1:0]  pin_out;
   logic [1:0]  pin_oe;
   logic [31:0] rd;
   logic        err;
   int          failures = 0;
   int          comparisons = 0;

   periodic_timer_modes dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_pin_0(tp0), .timer_pin_1(tp1),
      .external_clock_pin(tck), .timer_pin_out(pin_out), .timer_pin_oe(pin_oe));
   timer_pins_model pins_u (.pclk(pclk), .timer_pin_0(tp0), .timer_pin_1(tp1),
      .external_clock_pin(tck));

   // ====================
   // Clock, bus tasks and comparison
   initial
      forever #10 pclk = ~pclk;

   // Waits on pready itself, so a slower answer only costs time.
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= {24'h0, d};
      pstrb   <= 4'h1;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic ee);
      apb(a, 1'b0, 8'h00);
      check(rd, {24'h0, e}, "read data");
      check({31'h0, err}, {31'h0, ee}, "error response");
   endtask : rdchk

   // Loads compare and period values with the counter off, then starts it on pclk.
   task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
      apb(OFF_CTRL0, 1'b1, 8'h10);
      apb(OFF_CTRL1, 1'b1, c1);
      apb(OFF_COMPARE_A_LOW, 1'b1, a[7:0]);
      apb(OFF_COMPARE_A_HIGH, 1'b1, {6'h0, a[9:8]});
      apb(OFF_PERIOD_LOW, 1'b1, p[7:0]);
      apb(OFF_PERIOD_HIGH, 1'b1, {6'h0, p[9:8]});
      apb(OFF_FLAGS, 1'b1, 8'h03);
      apb(OFF_CTRL0, 1'b1, 8'h18);
   endtask : setup

   // A window that spans whole periods gives an exact count of high cycles.
   task automatic highs(input int settle, input int win, input logic [31:0] exp);
      int hi;
      hi = 0;
      repeat (settle) @(posedge pclk);
      repeat (win)
      begin
         @(posedge pclk);
         if (pin_out[0] === 1'b1)
            hi++;
      end
      check(hi, exp, "high cycles");
   endtask : highs

   // ====================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i < 9; i++)
         rdchk(8'(i * 4), 8'h00, 1'b0);
      apb(8'h24, 1'b1, 8'h5a);
      rdchk(8'h24, 8'h00, 1'b1);
      apb(OFF_COUNT_LOW, 1'b1, 8'h55);
      rdchk(OFF_COUNT_LOW, 8'h00, 1'b0);
      apb(OFF_COMPARE_A_HIGH, 1'b1, 8'hff);
      rdchk(OFF_COMPARE_A_HIGH, 8'h03, 1'b0);
      apb(OFF_PERIOD_HIGH, 1'b1, 8'hff);
      rdchk(OFF_PERIOD_HIGH, 8'h03, 1'b0);
   endtask : t_regs

   task automatic t_compare();
      logic [31:0] exp [4] = '{0, 0, 20, 10};
      for (int f = 0; f < 4; f++)
      begin
         setup({4'(f), 4'h0}, 10'd4, 10'd10);
         highs(20, 20, exp[f]);
      end
      rdchk(OFF_FLAGS, 8'h03, 1'b0);
      setup(8'h31, 10'd6, 10'd3);
      highs(12, 24, 12);
      rdchk(OFF_FLAGS, 8'h01, 1'b0);
      setup(8'h30, 10'd0, 10'd5);
      highs(20, 20, 0);
      rdchk(OFF_FLAGS, 8'h02, 1'b0);
      setup(8'h08, 10'd4, 10'd10);
      highs(1, 20, 20);
      setup(8'hc0, 10'd4, 10'd10);
      highs(30, 10, 0);
      rdchk(OFF_FLAGS, 8'h03, 1'b0);
      check({30'h0, pin_oe}, 32'h0, "timer pin enable");
   endtask : t_compare

   task automatic t_pwm();
      setup(8'ha8, 10'd3, 10'd8);
      highs(24, 24, 9);
      rdchk(OFF_FLAGS, 8'h03, 1'b0);
      setup(8'ha9, 10'd3, 10'd8);
      highs(24, 24, 9);
      setup(8'hac, 10'd3, 10'd8);
      highs(24, 24, 15);
      setup(8'ha0, 10'd3, 10'd8);
      highs(24, 24, 15);
      setup(8'h88, 10'd3, 10'd8);
      highs(24, 24, 0);
      setup(8'h98, 10'd3, 10'd8);
      highs(24, 24, 24);
      setup(8'ha8, 10'd9, 10'd8);
      highs(24, 24, 24);
      setup(8'ha8, 10'd512, 10'd0);
      highs(1024, 1024, 512);
   endtask : t_pwm

   task automatic t_pulse();
      int hi;
      setup(8'hb8, 10'd6, 10'd0);
      repeat (30) @(posedge pclk);
      rdchk(OFF_CTRL0, 8'h10, 1'b0);
      hi = 0;
      fork
         pins_u.pulse(2, 3);
         repeat (40)
         begin
            @(posedge pclk);
            hi += int'(pin_out[0] === 1'b1);
         end
      join
      check({31'h0, hi >= 6 && hi <= 8}, 32'h1, "pulse width");
      rdchk(OFF_CTRL0, 8'h10, 1'b0);
      apb(OFF_COMPARE_A_LOW, 1'b1, 8'hc8);
      apb(OFF_CTRL0, 1'b1, 8'h18);
      apb(OFF_CTRL0, 1'b1, 8'h10);
      highs(0, 20, 0);
   endtask : t_pulse

   task automatic t_capture();
      setup(8'h70, 10'd0, 10'd20);
      repeat (60) @(posedge pclk);
      rdchk(OFF_FLAGS, 8'h02, 1'b0);
      setup(8'h40, 10'd0, 10'd0);
      repeat (100) @(posedge pclk);
      pins_u.pulse(0, 4);
      rdchk(OFF_FLAGS, 8'h01, 1'b0);
      apb(OFF_COMPARE_A_LOW, 1'b0, 8'h00);
      check({31'h0, rd >= 95 && rd <= 115}, 32'h1, "captured count");
      apb(OFF_CTRL1, 1'b1, 8'h70);
      apb(OFF_FLAGS, 1'b1, 8'h03);
      pins_u.pulse(1, 4);
      rdchk(OFF_FLAGS, 8'h00, 1'b0);
      apb(OFF_CTRL1, 1'b1, 8'h52);
      pins_u.pulse(2, 4);
      rdchk(OFF_FLAGS, 8'h01, 1'b0);
      apb(OFF_CTRL1, 1'b1, 8'h60);
      apb(OFF_FLAGS, 1'b1, 8'h03);
      pins_u.pulse(1, 4);
      rdchk(OFF_FLAGS, 8'h01, 1'b0);
   endtask : t_capture

   // ====================
   // Sequence, watchdog and verdict
   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   // The tests need well under 20000 cycles; a hang is cut at 50000.
   initial
   begin
      #1000000;
      failures++;
      complete_run();
   end

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_compare();
      t_pwm();
      t_pulse();
      t_capture();
      complete_run();
   end
endmodule : periodic_timer_modes_test

// ### pin_events_if.sv
/*
 * Carrier for synchronised pin levels and edge pulses.
 * Assumes both ends run on pclk.
 */
interface pin_events_if
   import timer_pkg::*;
   ();
   logic [NPINS-1:0] level;
   logic [NPINS-1:0] rise;
   logic [NPINS-1:0] fall;

   modport producer (output level, output rise, output fall);
   modport consumer (input level, input rise, input fall);
endinterface : pin_events_if

// ### pin_sync.sv
/*
 * Two-flop synchronisers and edge detectors for the timer input pins.
 * Assumes the pins are asynchronous to pclk; edges are one pclk wide.
 */
module pin_sync
   import timer_pkg::*;
   (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [NPINS-1:0] pins_async,
   pin_events_if.producer        ev
   );

   // =======================================================================
   // Per-pin synchroniser
   genvar i;
   generate
      for (i = 0; i < NPINS; i++)
      begin : g_pin
         logic meta_ff;
         logic sync_ff;
         logic last_ff;

         // The first stage feeds only the second; edges use later stages.
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
               last_ff <= 1'b0;
            end
            else
            begin
               meta_ff <= pins_async[i];
               sync_ff <= meta_ff;
               last_ff <= sync_ff;
            end
         end

         // Edge pulses from the settled stages.
         assign ev.level[i] = sync_ff;
         assign ev.rise[i]  = sync_ff & ~last_ff;
         assign ev.fall[i]  = ~sync_ff & last_ff;
      end
   endgenerate

endmodule : pin_sync

// ### timer_pins_model.sv
/*
 * Far-side pin model: drives both timer pins and the external clock pin.
 * Assumes the bench calls pulse() right after a rising pclk edge.
 */
module timer_pins_model
   (
   input  wire logic pclk,
   output logic      timer_pin_0,
   output logic      timer_pin_1,
   output logic      external_clock_pin
   );
   timeunit 1ns;
   timeprecision 1ns;

   logic [2:0] pins_ff = 3'b000;

   // Pins idle low, as with a pull-down on an undriven line.
   assign {external_clock_pin, timer_pin_1, timer_pin_0} = pins_ff;

   // Each level is held for several edges so the synchroniser cannot miss it.
   task automatic pulse(input int idx, input int hold);
      pins_ff[idx] <= 1'b1;
      repeat (hold) @(posedge pclk);
      pins_ff[idx] <= 1'b0;
      repeat (hold) @(posedge pclk);
   endtask : pulse
endmodule : timer_pins_model

// ### timer_pkg.sv
/*
 * Constants shared by the periodic timer: register offsets, field positions,
 * reset values, mode and pin-function codes and prescaler taps.
 * Assumes a 32-bit APB slave with each 8-bit register in one aligned word.
 */
package timer_pkg;

   // =======================================================================
   // Sizes
   localparam int          CNT_W   = 10;
   localparam int          NPINS   = 3;
   localparam int          PIN_TP0 = 0;
   localparam int          PIN_TP1 = 1;
   localparam int          PIN_EXT = 2;
   localparam logic [9:0]  CNT_MAX = 10'h3ff;
   localparam logic [10:0] FULL_PERIOD = 11'h400;

   // =======================================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL0       = 8'h00;
   localparam logic [7:0] OFF_CTRL1       = 8'h04;
   localparam logic [7:0] OFF_COUNT_LOW   = 8'h08;
   localparam logic [7:0] OFF_COUNT_HIGH  = 8'h0c;
   localparam logic [7:0] OFF_COMPARE_A_LOW  = 8'h10;
   localparam logic [7:0] OFF_COMPARE_A_HIGH = 8'h14;
   localparam logic [7:0] OFF_PERIOD_LOW  = 8'h18;
   localparam logic [7:0] OFF_PERIOD_HIGH = 8'h1c;
   localparam logic [7:0] OFF_FLAGS       = 8'h20;

   // =======================================================================
   // Field positions and reset values
   localparam int         CTRL0_PAUSE_BIT = 7;
   localparam int         CTRL0_CKS_LSB   = 4;
   localparam int         CTRL0_ON_BIT    = 3;
   localparam int         FLAG_A_BIT      = 0;
   localparam int         FLAG_P_BIT      = 1;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [9:0] RST_VAL10       = 10'h000;

   // =======================================================================
   // Mode, pin-function and clock-select codes
   localparam logic [1:0] MODE_COMPARE = 2'b00;
   localparam logic [1:0] MODE_CAPTURE = 2'b01;
   localparam logic [1:0] MODE_PWM     = 2'b10;
   localparam logic [1:0] MODE_TIMER   = 2'b11;
   localparam logic [1:0] PF_NONE      = 2'b00;
   localparam logic [1:0] PF_LOW       = 2'b01;
   localparam logic [1:0] PF_HIGH      = 2'b10;
   localparam logic [1:0] PF_TOGGLE    = 2'b11;
   localparam logic [2:0] CKS_SYS4     = 3'h0;
   localparam logic [2:0] CKS_FH       = 3'h1;
   localparam logic [2:0] CKS_FH16     = 3'h2;
   localparam logic [2:0] CKS_FH64     = 3'h3;
   localparam logic [2:0] CKS_EXT_RISE = 3'h6;
   localparam logic [2:0] CKS_EXT_FALL = 3'h7;

   // Prescaler taps: a tap fires when the masked bits are all ones.
   localparam logic [7:0] DIV4_MASK  = 8'h03;
   localparam logic [7:0] DIV16_MASK = 8'h0f;
   localparam logic [7:0] DIV64_MASK = 8'h3f;
   localparam logic [7:0] TBC_MASK   = 8'hff;

endpackage : timer_pkg
